// [logic/irq_vec_host.sv]
// host processor model: interrupt sense, acknowledge, muxed bus cycles
// Notes on behaviour
// - device pulls request low to ask
// - request held low until causes cleared
// - direct host branches, gives no acknowledge
// - vectored host acknowledges, samples vector byte
// - vector is restart opcode 11nnn111
// - buffer enable is or of request, acknowledge
// - single peripheral uses byte e7, address 0020
// - up to eight peripherals, distinct opcodes
// - invert request for active-high host input
// - muxed bus: address first half, data second
`timescale 1ns/10ps
module irq_vec_host
  import irq_vec_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_vectored,
  input  wire logic        i_active_high,
  input  wire logic        i_irq_enable,
  input  wire logic        i_instr_done,
  input  wire logic        i_cyc_start,
  input  wire logic        i_cyc_write,
  input  wire logic [7:0]  i_cyc_addr,
  input  wire logic [7:0]  i_cyc_wdata,
  output logic             o_host_direct_irq0_n,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_vector,
  output logic             o_taken,
  output logic             o_in_service,
  output logic [7:0]       o_cyc_rdata,
  output logic [7:0]       o_addr_latch,
  output logic             o_cyc_busy,
  irq_vec_if.host          bus_if
);
  typedef enum {st_idle, st_wait, st_ack, st_serve} irq_st_t;
  typedef enum {c_idle, c_addr, c_data} cyc_st_t;

  irq_st_t     st_r;
  irq_st_t     st_nxt;
  cyc_st_t     cst_r;
  cyc_st_t     cst_nxt;
  logic        int_hi;
  logic        req;
  logic        ack_n_r;
  logic        ack_n_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  vec_r;
  logic [7:0]  vec_nxt;
  logic        taken_r;
  logic        taken_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic [7:0]  addr_r;
  logic [7:0]  addr_nxt;
  logic [7:0]  wd_r;
  logic [7:0]  wd_nxt;
  logic [7:0]  rd_r;
  logic [7:0]  rd_nxt;
  logic [7:0]  alat_r;
  logic [7:0]  alat_nxt;

  // active-high input sees the inverted request
  assign int_hi = ~bus_if.irq_request_n;
  assign req = (i_active_high ? int_hi : ~bus_if.irq_request_n)
               & i_irq_enable;
  assign o_host_direct_irq0_n = bus_if.irq_request_n;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt    = st_r;
    ack_n_nxt = 1'b1;
    pc_nxt    = pc_r;
    vec_nxt   = vec_r;
    taken_nxt = 1'b0;
    unique case (st_r)
      st_idle:
        if (req)
          st_nxt = st_wait;
      st_wait:
        // a request withdrawn before the instruction ends gets no answer;
        // the answer also waits for a running bus cycle to finish
        if (!req)
          st_nxt = st_idle;
        else if (i_instr_done && cst_r == c_idle)
        begin
          if (i_vectored)
          begin
            st_nxt    = st_ack;
            ack_n_nxt = 1'b0;
          end
          else
          begin
            st_nxt    = st_serve;
            pc_nxt    = direct_loc;
            taken_nxt = 1'b1;
          end
        end
      st_ack:
      begin
        // vector sampled while acknowledge is low
        vec_nxt   = bus_if.bus;
        pc_nxt    = rst_address(bus_if.bus);
        taken_nxt = 1'b1;
        st_nxt    = st_serve;
      end
      st_serve:
        // request released once software cleared the causes
        if (bus_if.irq_request_n)
          st_nxt = st_idle;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r    <= st_idle;
      ack_n_r <= 1'b1;
      pc_r    <= 16'h0000;
      vec_r   <= 8'h00_00;
      taken_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      ack_n_r <= ack_n_nxt;
      pc_r    <= pc_nxt;
      vec_r   <= vec_nxt;
      taken_r <= taken_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // muxed bus: one address phase then one data phase
  always_comb
  begin
    cst_nxt  = cst_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    alat_nxt = alat_r;
    unique case (cst_r)
      c_idle:
        // no bus cycle may overlap the acknowledge cycle
        if (i_cyc_start && st_r != st_ack && st_nxt != st_ack)
        begin
          cst_nxt  = c_addr;
          wr_nxt   = i_cyc_write;
          addr_nxt = i_cyc_addr;
          wd_nxt   = i_cyc_wdata;
        end
      c_addr:
      begin
        alat_nxt = addr_r;
        cst_nxt  = c_data;
      end
      c_data:
      begin
        if (!wr_r)
          rd_nxt = bus_if.bus;
        cst_nxt = c_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cst_r  <= c_idle;
      wr_r   <= 1'b0;
      addr_r <= 8'h00_00;
      wd_r   <= 8'h00_00;
      rd_r   <= 8'h00_00;
      alat_r <= 8'h00_00;
    end
    else
    begin
      cst_r  <= cst_nxt;
      wr_r   <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      alat_r <= alat_nxt;
    end
  end

  assign bus_if.host_ale = (cst_r == c_addr);
  assign bus_if.host_ad_oe = (cst_r == c_addr) ||
                             (cst_r == c_data && wr_r);
  assign bus_if.host_ad_out = (cst_r == c_addr) ? addr_r : wd_r;
  assign bus_if.host_rd_n = ~(cst_r == c_data && !wr_r);
  assign bus_if.host_wr_n = ~(cst_r == c_data && wr_r);
  assign bus_if.host_ack_n = ack_n_r;
  assign bus_if.host_irq_enabled = i_irq_enable;

  assign o_pc = pc_r;
  assign o_vector = vec_r;
  assign o_taken = taken_r;
  assign o_in_service = (st_r == st_serve);
  assign o_cyc_rdata = rd_r;
  assign o_addr_latch = alat_r;
  assign o_cyc_busy = (cst_r != c_idle);
endmodule

// [logic/irq_vec_pkg.sv]
// shared constants for the vectored interrupt handshake
package irq_vec_pkg;
  localparam logic [7:0] rst_base    = 8'h00_C7;
  localparam logic [7:0] rst_last    = 8'h00_FF;
  localparam logic [7:0] dev_vector  = 8'h00_E7;
  localparam int         max_periph  = 8;
  localparam int         rst_n_lsb   = 3;
  localparam logic [15:0] rst_step   = 16'h0008;
  localparam logic [15:0] direct_loc = 16'h0003;
  localparam logic [15:0] last_loc   = 16'h0038;
  localparam logic [7:0] ale_cycles  = 8'h02;

  function automatic logic [7:0] rst_opcode(input logic [2:0] n);
    rst_opcode = rst_base | {2'b00, n, 3'b000};
  endfunction

  function automatic logic [15:0] rst_address(input logic [7:0] op);
    rst_address = {10'h000, op[5:3], 3'b000};
  endfunction
endpackage

// [logic/irq_vec_if.sv]
// interface joining the interrupt source and the host module
`timescale 1ns/10ps
interface irq_vec_if;
  logic       irq_request_n;
  logic       host_ack_n;
  logic       host_irq_enabled;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] host_ad_out;
  logic       host_ad_oe;
  logic       host_ale;
  logic       host_rd_n;
  logic       host_wr_n;
  logic [7:0] bus;

  // wired bus level resolved from the enables
  assign bus = dev_data_oe ? dev_data :
               host_ad_oe  ? host_ad_out : 8'h00_FF;

  modport dev
  (
    output irq_request_n,
    output dev_data,
    output dev_data_oe,
    input  host_ack_n,
    input  bus
  );
  modport host
  (
    input  irq_request_n,
    output host_ack_n,
    output host_irq_enabled,
    output host_ad_out,
    output host_ad_oe,
    output host_ale,
    output host_rd_n,
    output host_wr_n,
    input  bus
  );
endinterface

// [logic/vector_buffer.sv]
// gated vector byte driver
`timescale 1ns/10ps
module vector_buffer
  import irq_vec_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_req_n,
  input  wire logic       i_ack_n,
  input  wire logic [7:0] i_vector,
  output logic [7:0]      o_data,
  output logic            o_oe
);
  logic [7:0] data_r;
  logic [7:0] data_nxt;

  // enable is the inverted or of two active-low lines, high means drive
  assign o_oe = ~(i_req_n | i_ack_n);
  assign o_data = data_r;

  always_comb
  begin
    data_nxt = i_vector;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      data_r <= rst_base;
    else
      data_r <= data_nxt;
  end
endmodule

// [logic/irq_vec_device.sv]
// interrupt source end with vector answer on acknowledge
`timescale 1ns/10ps
module irq_vec_device
  import irq_vec_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_cause_set,
  input  wire logic [7:0] i_cause_clr,
  input  wire logic [2:0] i_vec_sel,
  input  wire logic       i_single,
  output logic [7:0]      o_pending,
  output logic            o_ack_seen,
  irq_vec_if.dev          bus_if
);
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic       req_n_r;
  logic       req_n_nxt;
  logic       ackd_r;
  logic       ackd_nxt;
  logic [7:0] vec;

  // fixed byte unless a slot in a multi-peripheral chain is chosen
  assign vec = i_single ? dev_vector : rst_opcode(i_vec_sel);

  always_comb
  begin
    // set beats clear so a cause arriving during clear is kept
    pend_nxt = (pend_r & ~i_cause_clr) | i_cause_set;
    req_n_nxt = ~(|pend_nxt);
    ackd_nxt = ~bus_if.host_ack_n & ~req_n_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pend_r  <= 8'h00_00;
      req_n_r <= 1'b1;
      ackd_r  <= 1'b0;
    end
    else
    begin
      pend_r  <= pend_nxt;
      req_n_r <= req_n_nxt;
      ackd_r  <= ackd_nxt;
    end
  end

  assign bus_if.irq_request_n = req_n_r;
  assign o_pending = pend_r;
  assign o_ack_seen = ackd_r;

  vector_buffer u_buf
  (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_req_n  (req_n_r),
    .i_ack_n  (bus_if.host_ack_n),
    .i_vector (vec),
    .o_data   (bus_if.dev_data),
    .o_oe     (bus_if.dev_data_oe)
  );
endmodule

// [tb/irq_vec_sva.sv]
// checker for the wires between interrupt source and host
`timescale 1ns/10ps
module irq_vec_sva
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       irq_request_n,
  input wire logic       host_ack_n,
  input wire logic [7:0] dev_data,
  input wire logic       dev_data_oe,
  input wire logic       host_ad_oe,
  input wire logic       host_ale,
  input wire logic       host_rd_n,
  input wire logic       host_wr_n,
  input wire logic [7:0] bus
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // buffer answers in the ack cycle and lets go right after
  sequence s_ack_cyc;
    dev_data_oe ##1 (host_ack_n && !dev_data_oe);
  endsequence
  property p_ack_seq; $fell(host_ack_n) |-> s_ack_cyc; endproperty
  a_ack_seq: assert property (p_ack_seq) else $error("bad ack");
  property p_ack_req; !host_ack_n |-> !irq_request_n; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack no req");
  property p_oe; dev_data_oe == !(irq_request_n || host_ack_n); endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
  property p_bus_dev; dev_data_oe |-> bus == dev_data; endproperty
  a_bus_dev: assert property (p_bus_dev) else $error("bus lost");
  property p_vec; dev_data_oe |-> bus[7:6] == 2'b11 && bus[2:0] == 3'b111;
  endproperty
  a_vec: assert property (p_vec) else $error("not restart");
  // an idle bus must read as the pulled level, never a stale byte
  property p_float; !dev_data_oe && !host_ad_oe |-> bus == 8'hFF; endproperty
  a_float: assert property (p_float) else $error("bus driven");
  property p_ale_ph; host_ale |-> host_ad_oe && host_rd_n && host_wr_n;
  endproperty
  a_ale_ph: assert property (p_ale_ph) else $error("bad addr");
  property p_ale_nx; host_ale |=> !host_ale && (host_rd_n != host_wr_n);
  endproperty
  a_ale_nx: assert property (p_ale_nx) else $error("bad data");
  // the host keeps off the bus while the vector is on it
  property p_ack_bus;
    !host_ack_n |-> !host_ad_oe && host_rd_n && host_wr_n;
  endproperty
  a_ack_bus: assert property (p_ack_bus) else $error("ack clash");
endmodule

// [tb/testbench.sv]
// testbench joining both ends of the vectored interrupt handshake
`timescale 1ns/10ps
module testbench;
  import irq_vec_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic [7:0]  c_set = 0, c_clr = 0, addr = 0, wdata = 0;
  logic [2:0]  sel = 0;
  logic        single = 1, vect = 1, act_hi = 0, irq_en = 1;
  logic        done = 0, start = 0, wr = 0;
  logic [15:0] pc;
  logic [7:0]  vec, rdata, alatch, pend;
  logic        taken, ack_seen, in_svc, irq0_n, busy;
  int          miscompares = 0, cmp_count = 0, cycles = 0, acks = 0;

  irq_vec_if ifc ();
  irq_vec_device irq_vec_device_i (.i_clk(clk), .i_rst(rst),
    .i_cause_set(c_set), .i_cause_clr(c_clr), .i_vec_sel(sel),
    .i_single(single), .o_pending(pend), .o_ack_seen(ack_seen),
    .bus_if(ifc));
  irq_vec_host irq_vec_host_i (.i_clk(clk), .i_rst(rst), .i_vectored(vect),
    .i_active_high(act_hi), .i_irq_enable(irq_en), .i_instr_done(done),
    .i_cyc_start(start), .i_cyc_write(wr), .i_cyc_addr(addr),
    .i_cyc_wdata(wdata), .o_host_direct_irq0_n(irq0_n), .o_pc(pc),
    .o_vector(vec), .o_taken(taken), .o_in_service(in_svc),
    .o_cyc_rdata(rdata), .o_addr_latch(alatch), .o_cyc_busy(busy),
    .bus_if(ifc));
  irq_vec_sva irq_vec_sva_i (.i_clk(clk), .i_rst(rst),
    .irq_request_n(ifc.irq_request_n), .host_ack_n(ifc.host_ack_n),
    .dev_data(ifc.dev_data), .dev_data_oe(ifc.dev_data_oe),
    .host_ad_oe(ifc.host_ad_oe), .host_ale(ifc.host_ale),
    .host_rd_n(ifc.host_rd_n), .host_wr_n(ifc.host_wr_n), .bus(ifc.bus));
  ////////////////////////////////////////
  always #50 clk = ~clk;

  always @(posedge clk)
    if (ifc.host_ack_n === 1'b0)
      acks <= acks + 1;

  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // two causes so that clearing one must leave the request standing
  task service(input logic v, input logic s, input logic [2:0] n,
               input logic [15:0] ev, input logic [15:0] ep);
    int k;
    int a0;
    @(posedge clk);
    vect <= v;
    single <= s;
    sel <= n;
    act_hi <= n[0];
    c_set <= 8'h03;
    @(posedge clk);
    c_set <= 8'h00;
    #1 chk(16'(ifc.irq_request_n), 16'h0000);
    chk(16'(irq0_n), 16'h0000);
    a0 = acks;
    @(posedge clk) done <= 1'b1;
    k = 0;
    while (taken !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      #1 k++;
    end
    if (v)
      chk(16'(vec), ev);
    chk(pc, ep);
    chk(16'(acks - a0), 16'(v));
    chk(16'(ack_seen), 16'(v));
    chk(16'(in_svc), 16'h0001);
    @(posedge clk) done <= 1'b0;
    c_clr <= 8'h01;
    @(posedge clk) c_clr <= 8'h00;
    #1 chk(16'(ifc.irq_request_n), 16'h0000);
    chk(16'(pend), 16'h0002);
    chk(16'(in_svc), 16'h0001);
    @(posedge clk) c_clr <= 8'h02;
    @(posedge clk) c_clr <= 8'h00;
    #1 chk(16'(ifc.irq_request_n), 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk(16'(in_svc), 16'h0000);
  endtask

  // a read sees the idle bus, so d is the pulled level there
  task cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk) start <= 1'b0;
    #1 chk(16'(ifc.host_ale), 16'h0001);
    chk(16'(busy), 16'h0001);
    chk(16'(ifc.bus), 16'(a));
    @(posedge clk);
    #1 chk(16'(ifc.bus), 16'(d));
    @(posedge clk);
    #1 chk(16'(alatch), 16'(a));
    chk(16'(busy), 16'h0000);
    if (!w)
      chk(16'(rdata), 16'(d));
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      stop_test;
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    service(1, 1, 0, 16'h00E7, 16'h0020);
    $display("test single vector done");
    for (int n = 0; n < max_periph; n++)
      service(1, 0, n[2:0], 16'h00C7 | 16'(n * 8), 16'(n * 8));
    $display("test restart table done");
    // a masked request must stand without being serviced
    @(posedge clk);
    irq_en <= 1'b0;
    c_set <= 8'h01;
    done <= 1'b1;
    @(posedge clk) c_set <= 8'h00;
    repeat (4) @(posedge clk);
    #1 chk(16'(ifc.host_irq_enabled), 16'h0000);
    chk(16'(in_svc), 16'h0000);
    chk(16'(ifc.irq_request_n), 16'h0000);
    @(posedge clk) c_clr <= 8'h01;
    done <= 1'b0;
    @(posedge clk) c_clr <= 8'h00;
    irq_en <= 1'b1;
    $display("test interrupt mask done");
    service(0, 1, 0, 16'h0000, 16'h0003);
    $display("test direct host done");
    cyc(1, 8'h5A, 8'hA5);
    // read with a request pending but no acknowledge: buffer stays off
    @(posedge clk) c_set <= 8'h01;
    @(posedge clk) c_set <= 8'h00;
    #1 chk(16'(ifc.irq_request_n), 16'h0000);
    cyc(0, 8'h3C, 8'hFF);
    c_clr <= 8'h01;
    @(posedge clk) c_clr <= 8'h00;
    $display("test bus cycles done");
    stop_test;
  end
endmodule
